// ===== verilog/dlcs_pkg.sv
// Constants, field layouts and carrier types of the debug link register set
package dlcs_pkg;

  // Register offsets on the link's control space
  localparam logic [3:0] ADDR_REV     = 4'h0;
  localparam logic [3:0] ADDR_ERR     = 4'h1;
  localparam logic [3:0] ADDR_LINK_CONTROL_A   = 4'h2;
  localparam logic [3:0] ADDR_LINK_CONTROL_B   = 4'h3;
  localparam logic [3:0] ADDR_KEY     = 4'h7;
  localparam logic [3:0] ADDR_SYSTEM_RESET_REQUEST_CODE  = 4'h8;
  localparam logic [3:0] ADDR_CLKSEL  = 4'h9;
  localparam logic [3:0] ADDR_SYSCTL  = 4'ha;
  localparam logic [3:0] ADDR_SYSSTAT = 4'hb;
  localparam logic [3:0] ADDR_CRC     = 4'hc;

  // Field positions
  localparam int CA_INTER_BYTE_DELAY_ENABLE    = 7;
  localparam int CA_PARITY_CHECK_DISABLE     = 5;
  localparam int CA_DTD      = 4;
  localparam int CA_RSD      = 3;
  localparam int CB_NEGATIVE_ACK_DISABLE  = 4;
  localparam int CB_CONTENTION_DETECT_DISABLE = 3;
  localparam int CB_DISABLE  = 2;
  localparam int KEY_LSB     = 3;
  localparam int KEY_UROW    = 2;
  localparam int KEY_NVM     = 1;
  localparam int KEY_ERASE   = 0;
  localparam int SC_UROWDONE = 1;
  localparam int SC_CLKREQ   = 0;
  localparam int SS_ERASEF   = 6;
  localparam int SS_SYSRST   = 5;
  localparam int SS_SLEEP    = 4;
  localparam int SS_NVM_PROGRAM_KEY_STATUS  = 3;
  localparam int SS_UROWPROG = 2;
  localparam int SS_LOCK     = 0;

  localparam logic [7:0] LINK_CONTROL_A_MASK = 8'hbf;
  localparam logic [7:0] LINK_CONTROL_B_MASK = 8'h1c;

  // Error signature codes
  localparam logic [2:0] ERR_NONE    = 3'h0;
  localparam logic [2:0] ERR_PARITY  = 3'h1;
  localparam logic [2:0] ERR_FRAME   = 3'h2;
  localparam logic [2:0] ERR_TIMEOUT = 3'h3;
  localparam logic [2:0] ERR_START   = 3'h4;
  localparam logic [2:0] ERR_BUS     = 3'h6;
  localparam logic [2:0] ERR_CONTEND = 3'h7;

  localparam logic [7:0] RST_ASSERT  = 8'h59;
  localparam logic [7:0] RST_RELEASE = 8'h00;
  localparam logic [1:0] CLKSEL_DEF  = 2'h3;
  localparam logic [7:0] GUARD_MAX   = 8'h80;
  localparam logic [2:0] GT_RESERVED = 3'h7;
  localparam logic [2:0] GT_MIN_CODE = 3'h6;
  localparam logic [7:0] IDLE_BITS   = 8'h02;
  localparam int unsigned TIMEOUT_DEF = 65536;
  // Arbitrary revision value
  localparam logic [3:0] REV_DEF     = 4'h1;

  typedef enum logic [1:0] {
    PH_READY = 2'b00,
    PH_GUARD = 2'b01,
    PH_GAP   = 2'b10,
    PH_OFF   = 2'b11
  } dlcs_phase_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dlcs_reg_req_t;

  typedef struct packed {
    logic contention;
    logic bus;
    logic start;
    logic frame;
    logic parity;
  } dlcs_phy_evt_t;

  typedef struct packed {
    logic erase_fail;
    logic in_reset;
    logic in_sleep;
    logic nvm_prog;
    logic urow_prog;
    logic locked;
  } dlcs_sys_stat_t;

  typedef struct packed {
    dlcs_phase_t phase;
    logic [7:0]  cnt;
    logic [2:0]  err_sig;
    logic [7:0]  link_control_a;
    logic [7:0]  link_control_b;
    logic [2:0]  keys;
    logic [7:0]  rst_req;
    logic        rst_active;
    logic [1:0]  clk_sel;
    logic        urow_done;
    logic        clk_req;
    logic        sysrst_seen;
    logic [16:0] tmo_cnt;
    logic        tmo_hit;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        urow_pulse;
    logic        nack;
  } dlcs_state_t;

  localparam dlcs_state_t STATE_RST = '{
    phase:   PH_READY,
    clk_sel: CLKSEL_DEF,
    clk_req: 1'b1,
    default: '0
  };

endpackage : dlcs_pkg

// ===== verilog/dlcs_link_regs.sv
// Control and status register set of the single-wire debug link
`timescale 1ns/100ps
`default_nettype none

module dlcs_link_regs #(
  parameter int unsigned TIMEOUT_CYCLES = dlcs_pkg::TIMEOUT_DEF
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  // Register access from the link instruction decoder
  input  wire dlcs_pkg::dlcs_reg_req_t  cs_req,
  output logic [7:0]                    cs_rdata,
  output logic                          cs_rvalid,
  // Receiver and transmitter status
  input  wire dlcs_pkg::dlcs_phy_evt_t  phy_evt,
  input  wire logic                     rx_stop_done,
  input  wire logic                     tx_byte_done,
  input  wire logic                     tx_multi_load,
  input  wire logic                     tx_bit_tick,
  input  wire logic                     link_wake,
  // Access layer
  input  wire logic                     acc_wait,
  // Key decoder
  input  wire logic                     key_urow_ok,
  input  wire logic                     key_nvm_ok,
  input  wire logic                     key_erase_ok,
  input  wire logic                     nvm_prog_start,
  // System side status
  input  wire dlcs_pkg::dlcs_sys_stat_t sys_stat,
  input  wire logic [2:0]               crc_status,
  // Controls toward link and system
  output logic                          phy_enable,
  output logic                          tx_ready,
  output logic                          pin_drive_ok,
  output logic                          resp_sig_en,
  output logic                          contention_chk_en,
  output logic                          nack_send,
  output logic                          sys_reset_req,
  output logic                          sys_clk_req,
  output logic [1:0]                    clk_div_sel,
  output logic                          urow_done_pulse
);

  localparam logic [16:0] TMO_LAST = 17'(TIMEOUT_CYCLES - 1);
  localparam int KEY_BIT_UROW = dlcs_pkg::KEY_LSB + dlcs_pkg::KEY_UROW;

  dlcs_pkg::dlcs_state_t   st_q;
  dlcs_pkg::dlcs_state_t   st_d;
  dlcs_pkg::dlcs_phy_evt_t evt_m;
  dlcs_pkg::dlcs_reg_req_t req;
  logic                    tmo_fire;
  logic [2:0]              new_err;
  logic [7:0]              rd_mux;
  logic                    link_on;

  // Highest code wins when several errors land together
  function automatic logic [2:0] err_code(
    input dlcs_pkg::dlcs_phy_evt_t e,
    input logic                    tmo
  );
    logic [2:0] c;
    c = dlcs_pkg::ERR_NONE;
    if (e.parity)
      c = dlcs_pkg::ERR_PARITY;
    if (e.frame)
      c = dlcs_pkg::ERR_FRAME;
    if (tmo)
      c = dlcs_pkg::ERR_TIMEOUT;
    if (e.start)
      c = dlcs_pkg::ERR_START;
    if (e.bus)
      c = dlcs_pkg::ERR_BUS;
    if (e.contention)
      c = dlcs_pkg::ERR_CONTEND;
    return c;
  endfunction : err_code

  // Reserved code falls back to the shortest guard
  function automatic logic [7:0] guard_cycles(input logic [2:0] gt);
    logic [7:0] n;
    n = dlcs_pkg::GUARD_MAX >> (gt == dlcs_pkg::GT_RESERVED ?
                                dlcs_pkg::GT_MIN_CODE : gt);
    return n;
  endfunction : guard_cycles

  assign link_on = (st_q.phase != dlcs_pkg::PH_OFF);

  // Accesses are only honoured while the link is up
  always_comb
  begin
    req    = cs_req;
    req.wr = cs_req.wr & link_on;
    req.rd = cs_req.rd & link_on;
  end

  always_comb
  begin
    evt_m        = phy_evt;
    evt_m.parity = phy_evt.parity & ~st_q.link_control_a[dlcs_pkg::CA_PARITY_CHECK_DISABLE];
    evt_m.contention = phy_evt.contention &
                       ~st_q.link_control_b[dlcs_pkg::CB_CONTENTION_DETECT_DISABLE];
  end

  always_comb
  begin
    rd_mux = 8'h00;
    case (req.addr)
      dlcs_pkg::ADDR_REV:     rd_mux = {dlcs_pkg::REV_DEF, 4'h0};
      dlcs_pkg::ADDR_ERR:     rd_mux = {5'h00, st_q.err_sig};
      dlcs_pkg::ADDR_LINK_CONTROL_A:   rd_mux = st_q.link_control_a;
      dlcs_pkg::ADDR_LINK_CONTROL_B:   rd_mux = st_q.link_control_b;
      dlcs_pkg::ADDR_KEY:     rd_mux = {2'h0, st_q.keys, 3'h0};
      dlcs_pkg::ADDR_SYSTEM_RESET_REQUEST_CODE:  rd_mux = st_q.rst_req;
      dlcs_pkg::ADDR_CLKSEL:  rd_mux = {6'h00, st_q.clk_sel};
      dlcs_pkg::ADDR_SYSCTL:  rd_mux = {6'h00, st_q.urow_done, st_q.clk_req};
      dlcs_pkg::ADDR_SYSSTAT: rd_mux = {1'b0, sys_stat.erase_fail,
                                        st_q.sysrst_seen, sys_stat.in_sleep,
                                        sys_stat.nvm_prog, sys_stat.urow_prog,
                                        1'b0, sys_stat.locked};
      dlcs_pkg::ADDR_CRC:     rd_mux = {5'h00, crc_status};
      default:                rd_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    st_d            = st_q;
    st_d.rvalid     = 1'b0;
    st_d.urow_pulse = 1'b0;
    st_d.nack       = 1'b0;
    tmo_fire        = 1'b0;

    // Fires once per wait; the count restarts when the wait ends
    if (acc_wait && link_on && !st_q.link_control_a[dlcs_pkg::CA_DTD])
    begin
      if (st_q.tmo_cnt == TMO_LAST)
      begin
        tmo_fire     = ~st_q.tmo_hit;
        st_d.tmo_hit = 1'b1;
      end
      else
        st_d.tmo_cnt = st_q.tmo_cnt + 17'h00001;
    end
    else
    begin
      st_d.tmo_cnt = '0;
      st_d.tmo_hit = 1'b0;
    end

    new_err = err_code(evt_m, tmo_fire);

    // Register reads; clear-on-read loses to a same-cycle event
    if (req.rd)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd_mux;
      if (req.addr == dlcs_pkg::ADDR_ERR)
        st_d.err_sig = dlcs_pkg::ERR_NONE;
      if (req.addr == dlcs_pkg::ADDR_SYSSTAT)
        st_d.sysrst_seen = 1'b0;
    end
    if (new_err != dlcs_pkg::ERR_NONE)
      st_d.err_sig = new_err;
    if (sys_stat.in_reset)
      st_d.sysrst_seen = 1'b1;

    // Register writes
    if (req.wr)
    begin
      case (req.addr)
        dlcs_pkg::ADDR_LINK_CONTROL_A:
          st_d.link_control_a = req.wdata & dlcs_pkg::LINK_CONTROL_A_MASK;
        dlcs_pkg::ADDR_LINK_CONTROL_B:
          st_d.link_control_b = req.wdata & dlcs_pkg::LINK_CONTROL_B_MASK;
        dlcs_pkg::ADDR_KEY:
          if (req.wdata[KEY_BIT_UROW])
            st_d.keys[dlcs_pkg::KEY_UROW] = 1'b0;
        dlcs_pkg::ADDR_SYSTEM_RESET_REQUEST_CODE:
        begin
          st_d.rst_req = req.wdata;
          if (req.wdata == dlcs_pkg::RST_ASSERT)
          begin
            st_d.rst_active = 1'b1;
            st_d.keys[dlcs_pkg::KEY_ERASE] = 1'b0;
            st_d.nack = acc_wait & ~st_q.link_control_b[dlcs_pkg::CB_NEGATIVE_ACK_DISABLE];
          end
          else if (req.wdata == dlcs_pkg::RST_RELEASE)
            st_d.rst_active = 1'b0;
        end
        dlcs_pkg::ADDR_CLKSEL:
          st_d.clk_sel = req.wdata[1:0];
        dlcs_pkg::ADDR_SYSCTL:
        begin
          st_d.clk_req = req.wdata[dlcs_pkg::SC_CLKREQ];
          // Done may only be signalled after the user row key is in
          if (st_q.keys[dlcs_pkg::KEY_UROW])
          begin
            st_d.urow_done  = req.wdata[dlcs_pkg::SC_UROWDONE];
            st_d.urow_pulse = req.wdata[dlcs_pkg::SC_UROWDONE];
          end
        end
        default:
          st_d.rdata = st_d.rdata;
      endcase
    end

    // Key decode events; a new key beats a clear in the same cycle
    if (nvm_prog_start)
      st_d.keys[dlcs_pkg::KEY_NVM] = 1'b0;
    if (key_urow_ok)
      st_d.keys[dlcs_pkg::KEY_UROW] = 1'b1;
    if (key_nvm_ok)
      st_d.keys[dlcs_pkg::KEY_NVM] = 1'b1;
    if (key_erase_ok)
      st_d.keys[dlcs_pkg::KEY_ERASE] = 1'b1;

    // Turnaround and inter-byte spacing
    case (st_q.phase)
      dlcs_pkg::PH_READY,
      dlcs_pkg::PH_GAP:
      begin
        if (rx_stop_done)
        begin
          st_d.phase = dlcs_pkg::PH_GUARD;
          st_d.cnt   = guard_cycles(st_q.link_control_a[2:0]);
        end
        else if (tx_byte_done && tx_multi_load &&
                 st_q.link_control_a[dlcs_pkg::CA_INTER_BYTE_DELAY_ENABLE])
        begin
          st_d.phase = dlcs_pkg::PH_GAP;
          st_d.cnt   = dlcs_pkg::IDLE_BITS;
        end
        else if (st_q.phase == dlcs_pkg::PH_GAP && tx_bit_tick)
        begin
          if (st_q.cnt == 8'h01)
            st_d.phase = dlcs_pkg::PH_READY;
          else
            st_d.cnt = st_q.cnt - 8'h01;
        end
      end
      dlcs_pkg::PH_GUARD:
      begin
        if (rx_stop_done)
          st_d.cnt = guard_cycles(st_q.link_control_a[2:0]);
        else if (st_q.cnt == 8'h01)
          st_d.phase = dlcs_pkg::PH_READY;
        else
          st_d.cnt = st_q.cnt - 8'h01;
      end
      dlcs_pkg::PH_OFF:
        st_d.phase = dlcs_pkg::PH_OFF;
      default:
        st_d.phase = dlcs_pkg::PH_READY;
    endcase

    // Disable resets the link side but leaves a held system reset alone
    if (req.wr && req.addr == dlcs_pkg::ADDR_LINK_CONTROL_B &&
        req.wdata[dlcs_pkg::CB_DISABLE])
    begin
      st_d            = dlcs_pkg::STATE_RST;
      st_d.phase      = dlcs_pkg::PH_OFF;
      st_d.clk_req    = 1'b0;
      st_d.rst_req    = st_q.rst_req;
      st_d.rst_active = st_q.rst_active;
    end
    else if (link_wake && !link_on)
    begin
      st_d            = dlcs_pkg::STATE_RST;
      st_d.rst_req    = st_q.rst_req;
      st_d.rst_active = st_q.rst_active;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= dlcs_pkg::STATE_RST;
    else
      st_q <= st_d;
  end

  assign cs_rdata          = st_q.rdata;
  assign cs_rvalid         = st_q.rvalid;
  assign phy_enable        = link_on;
  assign tx_ready          = (st_q.phase == dlcs_pkg::PH_READY);
  assign pin_drive_ok      = link_on && (st_q.phase != dlcs_pkg::PH_GUARD);
  assign resp_sig_en       = ~st_q.link_control_a[dlcs_pkg::CA_RSD];
  assign contention_chk_en = ~st_q.link_control_b[dlcs_pkg::CB_CONTENTION_DETECT_DISABLE];
  assign nack_send         = st_q.nack;
  assign sys_reset_req     = st_q.rst_active;
  assign sys_clk_req       = st_q.clk_req & link_on;
  assign clk_div_sel       = st_q.clk_sel;
  assign urow_done_pulse   = st_q.urow_pulse;

  // Checks
  logic rd_err;
  logic no_evt;
  assign rd_err = req.rd && req.addr == dlcs_pkg::ADDR_ERR;
  assign no_evt = (phy_evt == '0) && !tmo_fire;

  sequence s_guard_hold;
    !pin_drive_ok [*2];
  endsequence

  property p_err_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      rd_err && no_evt |=> st_q.err_sig == dlcs_pkg::ERR_NONE;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error signature not cleared by read");

  property p_parity_code;
    @(posedge sys_clk) disable iff (!rst_b)
      link_on && phy_evt == 5'b00001 && !tmo_fire &&
      !st_q.link_control_a[dlcs_pkg::CA_PARITY_CHECK_DISABLE] |=> st_q.err_sig == 3'h1;
  endproperty
  a_parity_code: assert property (p_parity_code)
    else $error("parity error code wrong");

  property p_parity_off;
    @(posedge sys_clk) disable iff (!rst_b)
      phy_evt == 5'b00001 && !tmo_fire && !rd_err &&
      st_q.link_control_a[dlcs_pkg::CA_PARITY_CHECK_DISABLE] |=> $stable(st_q.err_sig);
  endproperty
  a_parity_off: assert property (p_parity_off)
    else $error("parity error recorded while disabled");

  property p_contention;
    @(posedge sys_clk) disable iff (!rst_b)
      link_on && phy_evt.contention &&
      !st_q.link_control_b[dlcs_pkg::CB_CONTENTION_DETECT_DISABLE] |=> st_q.err_sig == 3'h7;
  endproperty
  a_contention: assert property (p_contention)
    else $error("contention code not recorded");

  property p_timeout;
    @(posedge sys_clk) disable iff (!rst_b)
      tmo_fire && phy_evt == '0 |=> st_q.err_sig == 3'h3;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("time-out code not recorded");

  property p_guard_min;
    @(posedge sys_clk) disable iff (!rst_b)
      rx_stop_done && link_on && st_q.link_control_a[2:0] == 3'h6
        |=> s_guard_hold;
  endproperty
  a_guard_min: assert property (p_guard_min)
    else $error("pin driven inside guard time");

  property p_gap;
    @(posedge sys_clk) disable iff (!rst_b)
      link_on && !rx_stop_done && tx_byte_done && tx_multi_load &&
      st_q.link_control_a[dlcs_pkg::CA_INTER_BYTE_DELAY_ENABLE] |=> !tx_ready;
  endproperty
  a_gap: assert property (p_gap)
    else $error("no inter-byte gap");

  property p_rst_req;
    @(posedge sys_clk) disable iff (!rst_b)
      req.wr && req.addr == dlcs_pkg::ADDR_SYSTEM_RESET_REQUEST_CODE &&
      req.wdata == 8'h59 |=> sys_reset_req [*2];
  endproperty
  a_rst_req: assert property (p_rst_req)
    else $error("system reset not asserted");

  property p_disable;
    @(posedge sys_clk) disable iff (!rst_b)
      req.wr && req.addr == dlcs_pkg::ADDR_LINK_CONTROL_B &&
      req.wdata[dlcs_pkg::CB_DISABLE] |=> !phy_enable && !sys_clk_req &&
      st_q.link_control_a == 8'h00 && st_q.keys == 3'h0 && clk_div_sel == 2'h3;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable did not restore defaults");

  property p_nack;
    @(posedge sys_clk) disable iff (!rst_b)
      nack_send |-> $past(!st_q.link_control_b[dlcs_pkg::CB_NEGATIVE_ACK_DISABLE]);
  endproperty
  a_nack: assert property (p_nack)
    else $error("nack sent while disabled");

endmodule : dlcs_link_regs

`default_nettype wire

// ===== test/dlcs_dbg_model.sv
// Debugger-side model issuing register accesses on the link decoder port
`timescale 1ns/100ps
`default_nettype none

module dlcs_dbg_model (
  // Clock
  input  wire logic               sys_clk,
  // Register port
  output var dlcs_pkg::dlcs_reg_req_t cs_req,
  input  wire logic [7:0]         cs_rdata,
  input  wire logic               cs_rvalid
);

  initial
  begin
    cs_req = '0;
  end

  task automatic reg_wr(input logic [3:0] addr, input logic [7:0] data);
  begin
    @(posedge sys_clk);
    #1;
    cs_req.addr  = addr;
    cs_req.wdata = data;
    cs_req.wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    cs_req.wr    = 1'b0;
    // Unqualified data must not look like the last byte
    cs_req.wdata = ~data;
  end
  endtask : reg_wr

  // Replies are awaited under a fixed bound, never an open wait
  task automatic reg_rd(input logic [3:0] addr, output logic [7:0] data,
                        output logic got);
  begin
    @(posedge sys_clk);
    #1;
    cs_req.addr = addr;
    cs_req.rd   = 1'b1;
    @(posedge sys_clk);
    #1;
    cs_req.rd   = 1'b0;
    got  = 1'b0;
    data = 8'h00;
    for (int i = 0; i < 3 && !got; i++)
    begin
      if (cs_rvalid === 1'b1)
      begin
        got  = 1'b1;
        data = cs_rdata;
      end
      else
      begin
        @(posedge sys_clk);
        #1;
      end
    end
  end
  endtask : reg_rd

endmodule : dlcs_dbg_model
`default_nettype wire

// ===== test/test_debug_link_control_status_regs.sv
// Self-checking bench of the debug link register set
`timescale 1ns/100ps
`default_nettype none

module test_debug_link_control_status_regs;
  localparam int TMO = 16;
  logic sys_clk, rst_b, cs_rvalid, rx_stop_done, tx_byte_done;
  logic tx_multi_load, tx_bit_tick, link_wake, acc_wait, key_urow_ok;
  logic key_nvm_ok, key_erase_ok, nvm_prog_start, phy_enable, tx_ready;
  logic pin_drive_ok, resp_sig_en, contention_chk_en, nack_send;
  logic sys_reset_req, sys_clk_req, urow_done_pulse;
  logic [7:0] cs_rdata, d;
  logic [2:0] crc_status;
  logic [1:0] clk_div_sel;
  logic       got;
  dlcs_pkg::dlcs_reg_req_t  cs_req;
  dlcs_pkg::dlcs_phy_evt_t  phy_evt;
  dlcs_pkg::dlcs_sys_stat_t sys_stat;
  int mismatches, checks_done;
  int nack_cnt, urow_cnt;

  dlcs_link_regs #(.TIMEOUT_CYCLES(TMO)) dlcs_link_regs_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .cs_req(cs_req),
    .cs_rdata(cs_rdata), .cs_rvalid(cs_rvalid), .phy_evt(phy_evt),
    .rx_stop_done(rx_stop_done), .tx_byte_done(tx_byte_done),
    .tx_multi_load(tx_multi_load), .tx_bit_tick(tx_bit_tick),
    .link_wake(link_wake), .acc_wait(acc_wait), .key_urow_ok(key_urow_ok),
    .key_nvm_ok(key_nvm_ok), .key_erase_ok(key_erase_ok),
    .nvm_prog_start(nvm_prog_start), .sys_stat(sys_stat),
    .crc_status(crc_status), .phy_enable(phy_enable), .tx_ready(tx_ready),
    .pin_drive_ok(pin_drive_ok), .resp_sig_en(resp_sig_en),
    .contention_chk_en(contention_chk_en), .nack_send(nack_send),
    .sys_reset_req(sys_reset_req), .sys_clk_req(sys_clk_req),
    .clk_div_sel(clk_div_sel), .urow_done_pulse(urow_done_pulse));

  dlcs_dbg_model dlcs_dbg_model_i (.sys_clk(sys_clk), .cs_req(cs_req),
    .cs_rdata(cs_rdata), .cs_rvalid(cs_rvalid));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Pulses are short and their cycle is the designer's choice, so count them
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      nack_cnt <= 0;
      urow_cnt <= 0;
    end
    else
    begin
      if (nack_send === 1'b1)
        nack_cnt <= nack_cnt + 1;
      if (urow_done_pulse === 1'b1)
        urow_cnt <= urow_cnt + 1;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
  begin
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen,
               exp);
    end
  end
  endtask : chk

  task automatic cyc(input int n);
  begin
    repeat (n) @(posedge sys_clk);
    #1;
  end
  endtask : cyc

  task automatic pulse(ref logic s);
  begin
    @(posedge sys_clk);
    #1;
    s = 1'b1;
    @(posedge sys_clk);
    #1;
    s = 1'b0;
  end
  endtask : pulse

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
  begin
    dlcs_dbg_model_i.reg_wr(a, v);
    cyc(1);
  end
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
  begin
    dlcs_dbg_model_i.reg_rd(a, d, got);
    chk({7'h00, got}, 8'h01, "read answered");
    chk(d, exp, "read data");
  end
  endtask : rd_chk

  task automatic test_reset;
    logic [3:0] a [11];
    logic [7:0] e [11];
  begin
    a = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
    e = '{{dlcs_pkg::REV_DEF, 4'h0}, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
          8'h00, 8'h03, 8'h01, 8'h01, 8'h00};
    for (int i = 0; i < 11; i++)
      rd_chk(a[i], e[i]);
    wr(4'h0, 8'hff);
    rd_chk(4'h0, {dlcs_pkg::REV_DEF, 4'h0});
    chk({6'h00, clk_div_sel}, 8'h03, "clock select");
    chk({7'h00, sys_clk_req}, 8'h01, "clock request");
  end
  endtask : test_reset

  task automatic test_errors;
    dlcs_pkg::dlcs_phy_evt_t ev [5];
    logic [7:0] code [5];
  begin
    ev   = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
    code = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h07};
    for (int i = 0; i < 5; i++)
    begin
      @(posedge sys_clk);
      #1;
      phy_evt = ev[i];
      cyc(1);
      phy_evt = '0;
      rd_chk(4'h1, code[i]);
      rd_chk(4'h1, 8'h00);
    end
    acc_wait = 1'b1;
    cyc(TMO + 4);
    acc_wait = 1'b0;
    rd_chk(4'h1, 8'h03);
    wr(4'h2, 8'h30);
    acc_wait = 1'b1;
    cyc(TMO + 4);
    acc_wait = 1'b0;
    phy_evt = 5'h01;
    cyc(1);
    phy_evt = '0;
    rd_chk(4'h1, 8'h00);
    chk({7'h00, resp_sig_en}, 8'h01, "signature enable");
    // Signatures go off whenever control A has its RSD bit set
    wr(4'h2, 8'hff);
    rd_chk(4'h2, dlcs_pkg::LINK_CONTROL_A_MASK);
    chk({7'h00, resp_sig_en}, 8'h00, "signature disable");
    wr(4'h2, 8'h00);
    chk({7'h00, resp_sig_en}, 8'h01, "signature enable");
  end
  endtask : test_errors

  task automatic test_guard;
    int n;
  begin
    for (int gt = 0; gt < 8; gt++)
    begin
      wr(4'h2, 8'(gt));
      pulse(rx_stop_done);
      n = 0;
      while (pin_drive_ok !== 1'b1 && n < 300)
      begin
        n++;
        cyc(1);
      end
      chk(8'(n), (gt == 7) ? 8'h02 : 8'(128 >> gt), "guard");
    end
  end
  endtask : test_guard

  task automatic test_gap;
  begin
    wr(4'h2, 8'h80);
    tx_multi_load = 1'b1;
    pulse(tx_byte_done);
    chk({7'h00, tx_ready}, 8'h00, "gap start");
    pulse(tx_bit_tick);
    chk({7'h00, tx_ready}, 8'h00, "gap one bit");
    pulse(tx_bit_tick);
    cyc(1);
    chk({7'h00, tx_ready}, 8'h01, "gap end");
    wr(4'h2, 8'h00);
    pulse(tx_byte_done);
    chk({7'h00, tx_ready}, 8'h01, "no gap");
    tx_multi_load = 1'b0;
  end
  endtask : test_gap

  task automatic test_system_reset_request_code;
    int n0;
  begin
    for (int k = 0; k < 2; k++)
    begin
      wr(4'h3, k ? 8'h10 : 8'h00);
      n0 = nack_cnt;
      acc_wait  = 1'b1;
      wr(4'h8, dlcs_pkg::RST_ASSERT);
      acc_wait  = 1'b0;
      chk({7'h00, sys_reset_req}, 8'h01, "reset asserted");
      chk(8'(nack_cnt - n0), k ? 8'h00 : 8'h01, "nack");
      wr(4'h8, 8'h12);
      rd_chk(4'h8, 8'h12);
      chk({7'h00, sys_reset_req}, 8'h01, "reserved code");
      wr(4'h8, dlcs_pkg::RST_RELEASE);
      chk({7'h00, sys_reset_req}, 8'h00, "reset released");
    end
    wr(4'h3, 8'h08);
    chk({7'h00, contention_chk_en}, 8'h00, "contention off");
    wr(4'h3, 8'h00);
    chk({7'h00, contention_chk_en}, 8'h01, "contention on");
  end
  endtask : test_system_reset_request_code

  task automatic test_disable;
    int n0;
  begin
    pulse(key_urow_ok);
    pulse(key_nvm_ok);
    pulse(key_erase_ok);
    rd_chk(4'h7, 8'h38);
    pulse(nvm_prog_start);
    rd_chk(4'h7, 8'h28);
    n0 = urow_cnt;
    wr(4'ha, 8'h03);
    chk(8'(urow_cnt - n0), 8'h01, "user row done");
    wr(4'h7, 8'h20);
    rd_chk(4'h7, 8'h08);
    wr(4'ha, 8'h02);
    chk({7'h00, sys_clk_req}, 8'h00, "clock request low");
    // Without the user row key the done bit must not move again
    wr(4'ha, 8'h03);
    chk(8'(urow_cnt - n0), 8'h01, "user row done once");
    rd_chk(4'ha, 8'h03);
    wr(4'h2, 8'h85);
    wr(4'h9, 8'h00);
    chk({6'h00, clk_div_sel}, 8'h00, "clock select");
    wr(4'h3, 8'h04);
    chk({7'h00, phy_enable}, 8'h00, "link off");
    chk({7'h00, sys_clk_req}, 8'h00, "clock request");
    dlcs_dbg_model_i.reg_rd(4'h2, d, got);
    chk({7'h00, got}, 8'h00, "refused read");
    pulse(link_wake);
    cyc(1);
    chk({7'h00, phy_enable}, 8'h01, "link on");
    rd_chk(4'h2, 8'h00);
    rd_chk(4'h7, 8'h00);
    rd_chk(4'h9, 8'h03);
  end
  endtask : test_disable

  task automatic test_crc;
    logic [2:0] v [4];
  begin
    v = '{3'h0, 3'h1, 3'h2, 3'h4};
    for (int i = 0; i < 4; i++)
    begin
      crc_status = v[i];
      rd_chk(4'hc, {5'h00, v[i]});
    end
    sys_stat.in_reset = 1'b1;
    cyc(1);
    sys_stat.in_reset = 1'b0;
    rd_chk(4'hb, 8'h21);
    rd_chk(4'hb, 8'h01);
  end
  endtask : test_crc

  task automatic test_done;
  begin
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask : test_done

  // Bound is well above the expected run of about five hundred and forty cycles
  initial
  begin
    #(20000 * 8);
    mismatches++;
    test_done();
  end

  initial
  begin
    {rst_b, rx_stop_done, tx_byte_done, tx_multi_load, tx_bit_tick} = '0;
    {link_wake, acc_wait, key_urow_ok, key_nvm_ok, key_erase_ok} = '0;
    {nvm_prog_start, crc_status} = '0;
    phy_evt  = '0;
    sys_stat = '0;
    sys_stat.locked = 1'b1;
    mismatches  = 0;
    checks_done = 0;
    repeat (12) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    test_reset();
    test_errors();
    test_guard();
    test_gap();
    test_system_reset_request_code();
    test_disable();
    test_crc();
    test_done();
  end

endmodule : test_debug_link_control_status_regs
`default_nettype wire
